/* hw/psda_pkg.sv */
/*
  constants for the program-space data access bridge: register map,
  field positions, reset values and address widths.
  assumes nothing beyond a sv-2012 compiler.
*/
package psda_pkg;
  // register byte offsets on the ahb-lite slave
  localparam logic [7:0] OFF_TABLE_PAGE = 8'h00;
  localparam logic [7:0] OFF_WINDOW_PAGE = 8'h04;
  localparam logic [7:0] OFF_CORE_CONTROL = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  // field positions
  localparam int WINDOW_ENABLE_BIT = 2;
  localparam int CONFIG_SPACE_BIT = 7;
  localparam int EA_TOP_BIT = 15;
  // reset values
  localparam logic [7:0] TABLE_PAGE_RESET = 8'h00;
  localparam logic [7:0] WINDOW_PAGE_RESET = 8'h00;
  localparam logic [15:0] CORE_CONTROL_RESET = 16'h0000;
  // widths
  localparam int PADDR_W = 24;
  localparam int PWORD_W = 24;
  localparam int DATA_W = 16;
  localparam int WIN_LOW_W = 15;
  // extra cycles for a window read (one program read, result registered)
  localparam int WINDOW_STRETCH = 1;
  // table operation kinds
  typedef enum logic [1:0] {
    PSDA_TBL_READ_LOW = 2'b00,
    PSDA_TBL_READ_HIGH = 2'b01,
    PSDA_TBL_WRITE_LOW = 2'b10,
    PSDA_TBL_WRITE_HIGH = 2'b11
  } psda_tbl_op_t;
  // window read sequencer
  typedef enum logic [1:0] {
    PSDA_WIN_IDLE = 2'b00,
    PSDA_WIN_FETCH = 2'b01,
    PSDA_WIN_DONE = 2'b10
  } psda_win_state_t;
endpackage

/* hw/psda_table_path.sv */
/*
  table operation datapath: forms the 24-bit program address from the
  page and effective address, steers read bytes and write lanes.
  assumes the program word comes from the array one cycle after paddr, with op and ea held.
*/
`timescale 1ns/1ps
module psda_table_path (
  input wire logic [7:0] table_page,
  input wire logic [15:0] effective_address,
  input wire psda_pkg::psda_tbl_op_t op,
  input wire logic byte_mode,
  input wire logic [15:0] wdata,
  input wire logic [23:0] pword,
  output logic [23:0] paddr,
  output logic config_space,
  output logic [15:0] rdata,
  output logic [23:0] wword,
  output logic [2:0] wlane
);
  logic byte_sel;
  assign byte_sel = effective_address[0];
  // page above effective address; page top bit picks config space
  assign paddr = {table_page, effective_address};
  assign config_space = table_page[psda_pkg::CONFIG_SPACE_BIT];

  // read steering; the high byte above bit 23 is a phantom reading zero
  always_comb begin
    rdata = 16'h0000;
    case (op)
      psda_pkg::PSDA_TBL_READ_LOW: begin
        if (!byte_mode) rdata = pword[15:0];
        else rdata = {8'h00, byte_sel ? pword[15:8] : pword[7:0]};
      end
      psda_pkg::PSDA_TBL_READ_HIGH: begin
        if (!byte_mode) rdata = {8'h00, pword[23:16]};
        else rdata = byte_sel ? 16'h0000 : {8'h00, pword[23:16]};
      end
      default: rdata = 16'h0000;
    endcase
  end

  // write lanes, same addressing as reads
  always_comb begin
    wword = 24'h00_0000;
    wlane = 3'b000;
    case (op)
      psda_pkg::PSDA_TBL_WRITE_LOW: begin
        if (!byte_mode) begin
          wword = {8'h00, wdata};
          wlane = 3'b011;
        end else if (byte_sel) begin
          wword = {8'h00, wdata[7:0], 8'h00};
          wlane = 3'b010;
        end else begin
          wword = {16'h0000, wdata[7:0]};
          wlane = 3'b001;
        end
      end
      psda_pkg::PSDA_TBL_WRITE_HIGH: begin
        wword = {wdata[7:0], 16'h0000};
        wlane = (byte_mode && byte_sel) ? 3'b000 : 3'b100;
      end
      default: begin
        wword = 24'h00_0000;
        wlane = 3'b000;
      end
    endcase
  end
endmodule

/* hw/psda_window_map.sv */
/*
  visibility window address mapping and redirect decision.
  assumes core_control comes from a register on the same clock.
*/
`timescale 1ns/1ps
module psda_window_map (
  input wire logic [7:0] window_page,
  input wire logic [15:0] effective_address,
  input wire logic window_enable,
  input wire logic table_busy,
  output logic redirect,
  output logic [23:0] paddr
);
  // top ea bit plus enable; paused while a table op runs
  assign redirect = effective_address[psda_pkg::EA_TOP_BIT] && window_enable
                    && !table_busy;
  // bit 23 forced low, page bit 0 lands on bit 15, ea bit 15 dropped
  assign paddr = {1'b0, window_page, effective_address[14:0]};
endmodule

/* hw/psda_bridge.sv */
/*
  program-space data access bridge top: ahb-lite register slave, table
  operation port, data-space window port and program memory port.
  assumes a program memory array with one-cycle registered read data and
  a core that holds its request until done is seen.
*/
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module psda_bridge (
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // table operation request
  input wire logic tbl_req,
  input wire psda_pkg::psda_tbl_op_t tbl_op,
  input wire logic tbl_byte_mode,
  input wire logic [15:0] tbl_ea,
  input wire logic [15:0] tbl_wdata,
  output logic tbl_done,
  output logic [15:0] tbl_rdata,
  // data-space access from the core
  input wire logic data_req,
  input wire logic data_write,
  input wire logic [15:0] data_ea,
  output logic data_redirect,
  output logic data_done,
  output logic [15:0] data_rdata,
  // instruction fetch
  input wire logic fetch_advance,
  output logic [23:0] fetch_addr,
  // program memory array
  output logic pm_read,
  output logic pm_write,
  output logic [23:0] pm_addr,
  output logic pm_config,
  output logic [23:0] pm_wdata,
  output logic [2:0] pm_wlane,
  input wire logic [23:0] pm_rdata
);
  logic [7:0] table_page;
  logic [7:0] window_page;
  logic [15:0] core_control;
  logic ahb_pend;
  logic ahb_wr;
  logic [7:0] ahb_addr;
  logic tbl_busy;
  logic [15:0] tbl_rd_q;
  logic tbl_is_write;
  psda_pkg::psda_win_state_t win_state;
  psda_pkg::psda_win_state_t next_win_state;
  logic [15:0] win_rd_q;
  logic [23:0] tbl_paddr;
  logic tbl_cfg;
  logic [15:0] tbl_steer;
  logic [23:0] tbl_wword;
  logic [2:0] tbl_wlane;
  logic win_redirect;
  logic [23:0] win_paddr;
  logic [23:0] pc;
  logic [31:0] rd_mux;
  logic [7:0] next_table_page;
  logic [7:0] next_window_page;
  logic [15:0] next_core_control;
  logic tbl_take;
  logic win_take;

  // an ahb beat is live when selected with nonseq or seq
  function automatic logic ahb_live(input logic sel, input logic [1:0] trans);
    return sel && trans[1];
  endfunction

  // a window read starts only for a redirected read; window writes are dropped
  function automatic logic win_start(input logic req, input logic wr, input logic redir);
    return req && !wr && redir;
  endfunction

  // offset decode of read data; it reads the values the registers take at this
  // edge, so a read right behind a write to the same offset sees the new value
  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      psda_pkg::OFF_TABLE_PAGE: v = {24'h00_0000, next_table_page};
      psda_pkg::OFF_WINDOW_PAGE: v = {24'h00_0000, next_window_page};
      psda_pkg::OFF_CORE_CONTROL: v = {16'h0000, next_core_control};
      psda_pkg::OFF_STATUS: v = {29'h0000_0000, win_state != psda_pkg::PSDA_WIN_IDLE,
                                  tbl_busy, win_redirect};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  psda_table_path u_table (
    .table_page(table_page),
    .effective_address(tbl_ea),
    .op(tbl_op),
    .byte_mode(tbl_byte_mode),
    .wdata(tbl_wdata),
    .pword(pm_rdata),
    .paddr(tbl_paddr),
    .config_space(tbl_cfg),
    .rdata(tbl_steer),
    .wword(tbl_wword),
    .wlane(tbl_wlane)
  );

  psda_window_map u_window (
    .window_page(window_page),
    .effective_address(data_ea),
    .window_enable(core_control[psda_pkg::WINDOW_ENABLE_BIT]),
    .table_busy(tbl_busy || tbl_req),
    .redirect(win_redirect),
    .paddr(win_paddr)
  );

  // ahb address phase capture; zero wait states, always okay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ahb_pend <= 1'b0;
      ahb_wr <= 1'b0;
      ahb_addr <= 8'h00;
    end else if (hready) begin
      ahb_pend <= ahb_live(hsel, htrans);
      ahb_wr <= hwrite;
      ahb_addr <= haddr;
    end
  end

  // no wait states and no error: unmapped offsets simply read zero
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // register values after this edge; a data-phase write is folded in here so
  // that a read address phase on the same edge already returns the new value
  always_comb begin
    next_table_page = table_page;
    next_window_page = window_page;
    next_core_control = core_control;
    if (ahb_pend && ahb_wr) begin
      case (ahb_addr)
        psda_pkg::OFF_TABLE_PAGE: next_table_page = hwdata[7:0];
        psda_pkg::OFF_WINDOW_PAGE: next_window_page = hwdata[7:0];
        psda_pkg::OFF_CORE_CONTROL: next_core_control = hwdata[15:0];
        default: ;
      endcase
    end
  end

  // read mux on the address-phase offset; a process, not an assign, so the
  // register contents read inside the function also wake it
  always_comb begin
    rd_mux = reg_read(haddr);
  end

  // read data registered at the address phase so it stands in the data phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && ahb_live(hsel, htrans) && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // register writes land at the end of the data phase; hsize is ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      table_page <= psda_pkg::TABLE_PAGE_RESET;
      window_page <= psda_pkg::WINDOW_PAGE_RESET;
      core_control <= psda_pkg::CORE_CONTROL_RESET;
    end else begin
      table_page <= next_table_page;
      window_page <= next_window_page;
      core_control <= next_core_control;
    end
  end

  // table op: issue one cycle, result the next (array read latency 1)
  // tbl_req is still high at the edge that ends busy, so that edge never retakes it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tbl_busy <= 1'b0;
      tbl_is_write <= 1'b0;
    end else if (tbl_busy) begin
      tbl_busy <= 1'b0;
    end else if (tbl_take) begin
      tbl_busy <= 1'b1;
      tbl_is_write <= tbl_op[1];
    end
  end

  // capture steered read data when the array answers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tbl_rd_q <= 16'h0000;
    end else if (tbl_busy && !tbl_is_write) begin
      tbl_rd_q <= tbl_steer;
    end
  end
  assign tbl_done = tbl_busy;
  assign tbl_rdata = tbl_rd_q;

  // take conditions shared by the sequencers and the array port; a table op
  // wins the array, and the window map already stands down while one is live
  assign tbl_take = tbl_req && !tbl_busy;
  assign win_take = win_start(data_req, data_write, win_redirect);

  // window read sequencer: fetch then done adds the stretch cycle
  // a write never enters it: the window is read-only and answers at once
  always_comb begin
    next_win_state = win_state;
    case (win_state)
      psda_pkg::PSDA_WIN_IDLE: begin
        if (win_take) begin
          next_win_state = psda_pkg::PSDA_WIN_FETCH;
        end
      end
      psda_pkg::PSDA_WIN_FETCH: next_win_state = psda_pkg::PSDA_WIN_DONE;
      psda_pkg::PSDA_WIN_DONE: next_win_state = psda_pkg::PSDA_WIN_IDLE;
      default: next_win_state = psda_pkg::PSDA_WIN_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_state <= psda_pkg::PSDA_WIN_IDLE;
    end else begin
      win_state <= next_win_state;
    end
  end

  // only the low word of the program word is visible
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_rd_q <= 16'h0000;
    end else if (win_state == psda_pkg::PSDA_WIN_FETCH) begin
      win_rd_q <= pm_rdata[15:0];
    end
  end

  // writes into the window are dropped: the path is read-only
  assign data_redirect = data_req && win_redirect;
  assign data_done = (win_state == psda_pkg::PSDA_WIN_DONE)
                     || (data_redirect && data_write);
  assign data_rdata = win_rd_q;

  // fetch counter steps by two per program word
  // bit 0 stays zero and bit 23 is dropped, so fetches stay in user space
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc <= 24'h00_0000;
    end else if (fetch_advance) begin
      pc <= {pc[23:1] + 23'h00_0001, 1'b0};
    end
  end
  assign fetch_addr = {1'b0, pc[22:1], 1'b0};

  // program memory port; a table op takes the array before the window
  // with nothing to do the port idles on the fetch address with no strobe
  always_comb begin
    pm_read = 1'b0;
    pm_write = 1'b0;
    pm_addr = fetch_addr;
    pm_config = 1'b0;
    pm_wdata = 24'h00_0000;
    pm_wlane = 3'b000;
    if (tbl_take) begin
      pm_addr = tbl_paddr;
      pm_config = tbl_cfg;
      pm_read = !tbl_op[1];
      pm_write = tbl_op[1] && (tbl_wlane != 3'b000);
      pm_wdata = tbl_wword;
      pm_wlane = tbl_wlane;
    end else if (win_state == psda_pkg::PSDA_WIN_IDLE && win_take) begin
      pm_addr = win_paddr;
      pm_read = 1'b1;
    end
  end
endmodule

/* verif/psda_pm_model.sv */
/*
  program memory array model: one 24-bit word per address, lane writes,
  read data one edge after the strobe. assumes pm_* come from the bridge.
*/
`timescale 1ns/1ps
module psda_pm_model (
  input wire logic clk,
  input wire logic pm_read,
  input wire logic pm_write,
  input wire logic [23:0] pm_addr,
  input wire logic pm_config,
  input wire logic [23:0] pm_wdata,
  input wire logic [2:0] pm_wlane,
  output logic [23:0] pm_rdata
);
  logic [23:0] mem [logic [24:0]];
  logic [23:0] w;
  // unwritten words hold an address pattern, so a misrouted access shows
  function automatic logic [23:0] pat(input logic [24:0] a);
    return {a[23:16] ^ a[7:0] ^ {a[24], 7'h00}, a[15:0] ^ 16'h5a3c};
  endfunction
  initial pm_rdata = 24'h00_0000;
  // idle cycles invert the data so a stale word never passes for a fresh one
  always @(posedge clk) begin
    w = mem.exists({pm_config, pm_addr}) ? mem[{pm_config, pm_addr}] : pat({pm_config, pm_addr});
    if (pm_write) begin
      for (int i = 0; i < 3; i++) if (pm_wlane[i]) w[i*8 +: 8] = pm_wdata[i*8 +: 8];
      mem[{pm_config, pm_addr}] = w;
    end
    pm_rdata <= pm_read ? w : ~pm_rdata;
  end
endmodule

/* verif/psda_bridge_checker.sv */
/*
  port assertions for the bridge, bound below to psda_bridge.
  assumes one clock and an async active-high rst.
*/
`timescale 1ns/1ps
module psda_bridge_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic tbl_req,
  input wire psda_pkg::psda_tbl_op_t tbl_op,
  input wire logic [15:0] tbl_ea,
  input wire logic tbl_done,
  input wire logic data_req,
  input wire logic data_write,
  input wire logic [15:0] data_ea,
  input wire logic data_redirect,
  input wire logic data_done,
  input wire logic fetch_advance,
  input wire logic [23:0] fetch_addr,
  input wire logic pm_read,
  input wire logic pm_write,
  input wire logic [23:0] pm_addr,
  input wire logic pm_config
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // table access goes out in the take cycle, ea in the low half
  a_tbl_addr: assert property ($rose(tbl_req) |->
    pm_read == !tbl_op[1] && pm_addr[15:0] == tbl_ea) else $error("table address wrong");
  a_tbl_space: assert property ($rose(tbl_req) |-> pm_config == pm_addr[23])
    else $error("table space wrong");
  a_tbl_done: assert property ($rose(tbl_req) |-> !tbl_done ##1 tbl_done ##1 !tbl_done)
    else $error("table done timing wrong");
  // window fetches stay in user space with the ea low bits
  a_win_addr: assert property (data_redirect && pm_read |->
    !pm_addr[23] && !pm_config && pm_addr[14:0] == data_ea[14:0]) else $error("window addr wrong");
  a_win_gate: assert property (data_redirect |-> data_ea[15])
    else $error("redirect below window");
  a_win_stretch: assert property ($rose(data_req) && data_redirect && !data_write |->
    !data_done ##1 !data_done ##1 data_done) else $error("window read not stretched");
  a_win_suspend: assert property (tbl_req |-> !data_redirect)
    else $error("window live during table op");
  a_win_readonly: assert property (data_redirect && data_write |-> !pm_write && data_done)
    else $error("window write not dropped");
  a_fetch_step: assert property (fetch_advance |=>
    fetch_addr == $past(fetch_addr) + 24'h00_0002 && !fetch_addr[0]) else $error("fetch step wrong");
  a_fetch_hold: assert property (!fetch_advance |=> $stable(fetch_addr))
    else $error("fetch moved");
  c_cfg: cover property ($rose(tbl_req) && pm_config);
  c_win: cover property (data_done && data_redirect && !data_write);
  c_fetch: cover property (fetch_advance);
endmodule
bind psda_bridge psda_bridge_checker chk (.*);

/* verif/tb_psda_bridge.sv */
/*
  self-checking bench for psda_bridge: ahb-lite register access, table
  and window requests, fetch counter. assumes package and design compiled.
*/
`timescale 1ns/1ps
module tb_psda_bridge;
  logic clk, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hresp, hreadyout;
  logic tbl_req = 1'b0, tbl_byte_mode = 1'b0, tbl_done, pm_read, pm_write, pm_config;
  logic data_req = 1'b0, data_write = 1'b0, data_redirect, data_done, fetch_advance = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010, pm_wlane;
  logic [7:0] haddr = 8'h00, tp, wp;
  logic [31:0] hwdata = 32'h0000_0000, hrdata, r;
  logic [15:0] tbl_ea = 16'h0000, tbl_wdata = 16'h0000, data_ea = 16'h0000;
  logic [15:0] tbl_rdata, data_rdata, ea;
  logic [23:0] fetch_addr, pm_addr, pm_wdata, pm_rdata, p;
  psda_pkg::psda_tbl_op_t tbl_op = psda_pkg::PSDA_TBL_READ_LOW;
  logic [7:0] offs [5] = '{psda_pkg::OFF_TABLE_PAGE, psda_pkg::OFF_WINDOW_PAGE,
    psda_pkg::OFF_CORE_CONTROL, psda_pkg::OFF_STATUS, 8'h10};
  logic [31:0] exp_q [$];
  logic pend_h = 1'b0, pend_t = 1'b0;
  int fails = 0, total_checks = 0, n;
  wire hready = hreadyout;
  psda_bridge dut (.*);
  psda_pm_model pm (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [23:0] pat(input logic [24:0] a);
    return {a[23:16] ^ a[7:0] ^ {a[24], 7'h00}, a[15:0] ^ 16'h5a3c};
  endfunction
  // expected table read result from the program word and byte select
  function automatic logic [31:0] tres(input logic hi, bm, input logic [23:0] w, input logic s);
    if (!hi) return bm ? {24'h00_0000, s ? w[15:8] : w[7:0]} : {16'h0000, w[15:0]};
    return (bm && s) ? 32'h0000_0000 : {24'h00_0000, w[23:16]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // bounded waits; running out ends the run as a failure
  task automatic wait_done(input logic t);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((t ? tbl_done : data_done) !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      complete_run();
    end
  endtask
  task automatic hwait;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      complete_run();
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    if (!wr) exp_q.push_back(d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    hwait();
    htrans <= 2'b00;
    hwdata <= d;
    hwait();
  endtask
  task automatic tbl(input logic [1:0] op, input logic bm, input logic [15:0] e, wd);
    @(posedge clk);
    tbl_req <= 1'b1;
    tbl_op <= psda_pkg::psda_tbl_op_t'(op);
    tbl_byte_mode <= bm;
    tbl_ea <= e;
    tbl_wdata <= wd;
    wait_done(1'b1);
    @(posedge clk);
    tbl_req <= 1'b0;
  endtask
  task automatic rdt(input logic hi, bm, input logic [15:0] e, input logic [23:0] w);
    exp_q.push_back(tres(hi, bm, w, e[0]));
    tbl({1'b0, hi}, bm, e, 16'h0000);
  endtask
  task automatic win(input logic wr, input logic [15:0] e);
    @(posedge clk);
    data_req <= 1'b1;
    data_write <= wr;
    data_ea <= e;
    wait_done(1'b0);
    @(posedge clk);
    data_req <= 1'b0;
  endtask
  task automatic noredir(input logic [15:0] e);
    @(posedge clk);
    data_req <= 1'b1;
    data_write <= 1'b0;
    data_ea <= e;
    @(negedge clk);
    check(data_redirect, 32'h0000_0000);
    @(posedge clk);
    data_req <= 1'b0;
  endtask
  // results come back in issue order, so the oldest note is the match
  always @(negedge clk) begin
    if (pend_h) check(hrdata, exp_q.pop_front());
    if (pend_h) check({31'h0000_0000, hresp}, 32'h0000_0000);
    if (pend_t) check({16'h0000, tbl_rdata}, exp_q.pop_front());
    if (data_done === 1'b1 && data_redirect && !data_write)
      check({16'h0000, data_rdata}, exp_q.pop_front());
    pend_h = hsel && htrans == 2'b10 && !hwrite;
    pend_t = tbl_done === 1'b1 && !tbl_op[1];
  end
  initial begin
    #4_000_000;
    fails++;
    complete_run();
  end
  initial begin
    void'($urandom(8688));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (offs[i]) ahb(1'b0, offs[i], 32'h0000_0000);
    r = $urandom;
    ahb(1'b1, psda_pkg::OFF_WINDOW_PAGE, r);
    ahb(1'b0, psda_pkg::OFF_WINDOW_PAGE, {24'h00_0000, r[7:0]});
    ahb(1'b1, 8'h10, 32'hffff_ffff);
    ahb(1'b0, 8'h10, 32'h0000_0000);
    $display("test registers done");
    // every read kind, byte select and space
    for (int k = 0; k < 16; k++) begin
      tp = {k[3], 7'($urandom)};
      ea = {15'($urandom), k[2]};
      ahb(1'b1, psda_pkg::OFF_TABLE_PAGE, {24'h00_0000, tp});
      rdt(k[0], k[1], ea, pat({tp[7], tp, ea}));
    end
    $display("test table reads done");
    ea = {15'($urandom), 1'b0};
    r = $urandom;
    tbl(2'b10, 1'b0, ea, r[15:0]);
    tbl(2'b11, 1'b0, ea, r[31:16]);
    rdt(1'b0, 1'b0, ea, r[23:0]);
    rdt(1'b1, 1'b0, ea, r[23:0]);
    ea = ea | 16'h0001;
    p = pat({tp[7], tp, ea});
    tbl(2'b11, 1'b1, ea, 16'h00a5);
    tbl(2'b10, 1'b1, ea, 16'h005e);
    rdt(1'b0, 1'b0, ea, {p[23:16], 8'h5e, p[7:0]});
    rdt(1'b1, 1'b0, ea, p);
    $display("test table writes done");
    wp = 8'($urandom);
    ahb(1'b1, psda_pkg::OFF_WINDOW_PAGE, {24'h00_0000, wp});
    ahb(1'b1, psda_pkg::OFF_CORE_CONTROL, 32'h0000_0004);
    for (int k = 0; k < 6; k++) begin
      ea = {1'b1, 15'($urandom)};
      p = pat({2'b00, wp, ea[14:0]});
      exp_q.push_back({16'h0000, p[15:0]});
      win(1'b0, ea);
    end
    win(1'b1, 16'hc000);
    // a window read raised with a table read must stand down until it ends
    exp_q.push_back(tres(1'b0, 1'b0, pat({tp[7], tp, 16'h8002}), 1'b0));
    @(posedge clk);
    data_req <= 1'b1;
    data_write <= 1'b0;
    data_ea <= 16'h8002;
    tbl_req <= 1'b1;
    tbl_op <= psda_pkg::PSDA_TBL_READ_LOW;
    tbl_byte_mode <= 1'b0;
    tbl_ea <= 16'h8002;
    wait_done(1'b1);
    check(data_redirect, 32'h0000_0000);
    @(posedge clk);
    tbl_req <= 1'b0;
    data_req <= 1'b0;
    noredir(16'h1234);
    ahb(1'b1, psda_pkg::OFF_CORE_CONTROL, 32'h0000_0000);
    noredir(16'hc000);
    $display("test window done");
    // reset in mid-run: the pages must come back at their reset values
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    ahb(1'b0, psda_pkg::OFF_TABLE_PAGE, {24'h00_0000, psda_pkg::TABLE_PAGE_RESET});
    ahb(1'b0, psda_pkg::OFF_WINDOW_PAGE, {24'h00_0000, psda_pkg::WINDOW_PAGE_RESET});
    $display("test reset done");
    n = 5 + $urandom % 8;
    r = n;
    @(posedge clk);
    fetch_advance <= 1'b1;
    repeat (r) @(posedge clk);
    fetch_advance <= 1'b0;
    @(negedge clk);
    check(fetch_addr, 2 * r);
    $display("test fetch done");
    complete_run();
  end
endmodule
